/* rtl/ompc_pkg.sv */
// Package of constants and types for the operating mode power controller.
`default_nettype none
package ompc_pkg;
  // Register byte offsets.
  localparam logic [7:0] SYS_CLOCK_CONTROL_OFS = 8'h00;
  localparam logic [7:0] PORT_A_WAKE_ENABLE_OFS = 8'h04;
  localparam logic [7:0] OSC_STATUS_OFS = 8'h08;
  localparam logic [7:0] POWER_STATUS_OFS = 8'h0c;
  // Field positions in the clock control register.
  localparam int CKSEL_LSB = 5;
  localparam int LOW_SRC_BIT = 2;
  localparam int FAST_KEEP_BIT = 1;
  localparam int SLOW_KEEP_BIT = 0;
  localparam logic [7:0] SYS_CLOCK_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_A_WAKE_ENABLE_RESET = 8'h00;
  localparam logic [2:0] CKSEL_SUB = 3'h7;
  // Field positions in the power status register.
  localparam int PDF_BIT = 0;
  localparam int WDX_BIT = 1;
  localparam int MODE_LSB = 4;
  // Restart settle time after wake-up.
  localparam int CLOCK_MHZ = 40;
  localparam int RESTART_NS = 1000;
  localparam int RESTART_CYCLES = (RESTART_NS * CLOCK_MHZ + 999) / 1000;
  // Response codes of the bus.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OMPC_FAST = 3'h0,
    OMPC_SLOW = 3'h1,
    OMPC_SLEEP = 3'h2,
    OMPC_IDLE_SLOW = 3'h3,
    OMPC_IDLE_BOTH = 3'h4,
    OMPC_IDLE_FAST = 3'h5,
    OMPC_RESTART = 3'h6
  } ompc_mode_t;

  typedef struct packed {
    logic halt_cpu;
    logic high_clock_on;
    logic sub_clock_on;
    logic sub_from_crystal;
    logic [2:0] divide_sel;
    logic use_sub_clock;
  } ompc_clock_ctl_t;

  typedef struct packed {
    logic wake_full_reset;
    logic wake_watchdog_reset;
    logic wake_resume;
    logic watchdog_clear;
  } ompc_events_t;
endpackage : ompc_pkg
`default_nettype wire

/* rtl/ompc_edge_sync.sv */
// Two-stage synchroniser with falling-edge detector for a bank of pins.
`default_nettype none
module ompc_edge_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins in and edges out
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_fall;

  always_comb begin
    next_fall = stage3 & ~stage2;
  end

  // Reset to ones, so a pin held low at reset is taken as a falling edge once reset is released.
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
      fall <= '0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      fall <= next_fall;
    end
  end
endmodule : ompc_edge_sync
`default_nettype wire

/* rtl/ompc_controller.sv */
// Operating mode controller: clock source selection, stop modes and wake-up.
//
// How it works
// - Select value 111 in fast mode moves the system clock to the sub-clock.
// - Sub-clock source chosen by the low source bit; switch waits for stability.
// - Select values 000 to 110 give fast mode at high clock over 1 to 64.
// - Stop with both keep-alive bits clear enters sleep; only the watchdog runs.
// - Stop with only slow keep-alive set enters idle-slow; high clock stops.
// - Stop with both keep-alive bits set enters idle-both; both clocks run.
// - Stop with only fast keep-alive set enters idle-fast; sub-clock stops.
// - In any stop mode the cpu halts and all state is kept.
// - Stop entry sets the power-down flag and clears the watchdog-expired flag.
// - Stop entry clears the watchdog, which then runs only if enabled.
// - Port A falling edge, reset, interrupt or watchdog overflow wakes the device.
// - Reset wake gives full reset; watchdog wake starts a watchdog reset.
// - Power-down flag cleared by power-up or clear-watchdog, set by stop.
// - Watchdog timeout in stop sets the expired flag and resets only pc and sp.
// - Port A pins wake only when enabled; execution resumes after the stop.
// - After wake-up, wait for the oscillator to settle before resuming.
// - Interrupt wake with interrupt off or stack full resumes after the stop.
// - Interrupt already pending at stop entry cannot wake the device.
// - Low source bit 0 picks the low internal RC, 1 picks the low crystal.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
module ompc_controller
  import ompc_pkg::*;
#(
  parameter int PORT_WIDTH = 8,
  parameter int IRQ_WIDTH = 8
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // AXI4-Lite register slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Cpu side
  input wire logic CPU_STOP,
  input wire logic CPU_CLEAR_WATCHDOG,
  input wire logic [IRQ_WIDTH-1:0] IRQ_PENDING,
  input wire logic IRQ_SERVICEABLE,
  // Oscillators and watchdog
  input wire logic HIGH_STABLE,
  input wire logic LOW_CRYSTAL_STABLE,
  input wire logic LOW_RC_STABLE,
  input wire logic WATCHDOG_ENABLED,
  input wire logic WATCHDOG_OVERFLOW,
  // Pins
  input wire logic [PORT_WIDTH-1:0] PORT_A,
  input wire logic EXT_RESET_N,
  // Control outputs
  output ompc_pkg::ompc_clock_ctl_t CLOCK_CTL,
  output ompc_pkg::ompc_events_t EVENTS,
  output ompc_pkg::ompc_mode_t MODE
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] system_clock_control;
  logic [PORT_WIDTH-1:0] port_a_wake_enable;
  logic power_down_flag;
  logic watchdog_expired_flag;
  logic [7:0] next_system_clock_control;
  logic [PORT_WIDTH-1:0] next_port_a_wake_enable;
  logic next_power_down_flag;
  logic next_watchdog_expired_flag;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp;
  logic next_bvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;
  logic do_write;

  ompc_mode_t mode;
  ompc_mode_t next_mode;
  logic [15:0] settle;
  logic [15:0] next_settle;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic [IRQ_WIDTH-1:0] next_irq_mask;
  ompc_events_t next_events;
  ompc_clock_ctl_t next_clock_ctl;

  logic [PORT_WIDTH-1:0] port_fall;
  logic [1:0] ext_sync;
  logic ext_reset_n_s;
  logic low_stable;
  logic pin_wake;
  logic irq_wake;

  ompc_edge_sync #(.WIDTH(PORT_WIDTH)) u_port_sync (
    .clk(CLOCK),
    .rst(RESET),
    .pin(PORT_A),
    .fall(port_fall)
  );

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ext_sync <= 2'h3;
    end else begin
      ext_sync <= {ext_sync[0], EXT_RESET_N};
    end
  end
  assign ext_reset_n_s = ext_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register slave. Address and data may come in either order.
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bresp = S_AXI_BRESP;
    next_bvalid = S_AXI_BVALID;
    next_rdata = S_AXI_RDATA;
    next_rresp = S_AXI_RRESP;
    next_rvalid = S_AXI_RVALID;
    next_system_clock_control = system_clock_control;
    next_port_a_wake_enable = port_a_wake_enable;
    do_write = 1'b0;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_w_held = 1'b1;
      next_w_data = S_AXI_WDATA;
      next_w_strb = S_AXI_WSTRB;
    end
    if (aw_held && w_held) begin
      do_write = 1'b1;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case ({aw_addr[7:2], 2'h0})
        SYS_CLOCK_CONTROL_OFS: begin
          // Bit 4 is unimplemented and kept at zero.
          if (w_strb[0]) next_system_clock_control = w_data[7:0] & 8'hef;
        end
        PORT_A_WAKE_ENABLE_OFS: begin
          if (w_strb[0]) next_port_a_wake_enable = w_data[PORT_WIDTH-1:0];
        end
        OSC_STATUS_OFS, POWER_STATUS_OFS: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (S_AXI_BVALID && S_AXI_BREADY) next_bvalid = 1'b0;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0;
      case ({S_AXI_ARADDR[7:2], 2'h0})
        SYS_CLOCK_CONTROL_OFS: next_rdata = {24'h0, system_clock_control};
        PORT_A_WAKE_ENABLE_OFS: next_rdata[PORT_WIDTH-1:0] = port_a_wake_enable;
        OSC_STATUS_OFS: next_rdata = {29'h0, LOW_RC_STABLE, LOW_CRYSTAL_STABLE,
                                      HIGH_STABLE};
        POWER_STATUS_OFS: next_rdata = {25'h0, mode, 2'h0, watchdog_expired_flag,
                                        power_down_flag};
        default: next_rresp = RESP_SLVERR;
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      S_AXI_BRESP <= RESP_OKAY;
      S_AXI_BVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      system_clock_control <= SYS_CLOCK_CONTROL_RESET;
      port_a_wake_enable <= PORT_A_WAKE_ENABLE_RESET[PORT_WIDTH-1:0];
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      S_AXI_BRESP <= next_bresp;
      S_AXI_BVALID <= next_bvalid;
      S_AXI_RDATA <= next_rdata;
      S_AXI_RRESP <= next_rresp;
      S_AXI_RVALID <= next_rvalid;
      system_clock_control <= next_system_clock_control;
      port_a_wake_enable <= next_port_a_wake_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencer.
  assign low_stable = system_clock_control[LOW_SRC_BIT] ? LOW_CRYSTAL_STABLE
                                                        : LOW_RC_STABLE;
  assign pin_wake = |(port_fall & port_a_wake_enable);
  // Interrupts already pending at entry are masked out of the wake terms.
  assign irq_wake = |(IRQ_PENDING & ~irq_mask);

  always_comb begin
    next_mode = mode;
    next_settle = settle;
    next_irq_mask = irq_mask;
    next_events = '0;
    next_power_down_flag = power_down_flag;
    next_watchdog_expired_flag = watchdog_expired_flag;
    case (mode)
      OMPC_FAST, OMPC_SLOW: begin
        if (system_clock_control[7:CKSEL_LSB] == CKSEL_SUB) begin
          if (low_stable) next_mode = OMPC_SLOW;
        end else begin
          next_mode = OMPC_FAST;
        end
        if (CPU_STOP) begin
          next_irq_mask = IRQ_PENDING;
          next_events.watchdog_clear = 1'b1;
          next_power_down_flag = 1'b1;
          next_watchdog_expired_flag = 1'b0;
          case ({system_clock_control[FAST_KEEP_BIT], system_clock_control[SLOW_KEEP_BIT]})
            2'b00: next_mode = OMPC_SLEEP;
            2'b01: next_mode = OMPC_IDLE_SLOW;
            2'b11: next_mode = OMPC_IDLE_BOTH;
            default: next_mode = OMPC_IDLE_FAST;
          endcase
        end
      end
      OMPC_SLEEP, OMPC_IDLE_SLOW, OMPC_IDLE_BOTH, OMPC_IDLE_FAST: begin
        // Reset wake has priority, then the watchdog, then pins and interrupts.
        if (!ext_reset_n_s) begin
          next_events.wake_full_reset = 1'b1;
          next_mode = OMPC_FAST;
        end else if (WATCHDOG_OVERFLOW && WATCHDOG_ENABLED) begin
          next_events.wake_watchdog_reset = 1'b1;
          next_watchdog_expired_flag = 1'b1;
          next_settle = 16'(RESTART_CYCLES);
          next_mode = OMPC_RESTART;
        end else if (pin_wake || irq_wake) begin
          next_settle = 16'(RESTART_CYCLES);
          next_mode = OMPC_RESTART;
        end
      end
      OMPC_RESTART: begin
        if (settle > 16'h1) begin
          next_settle = settle - 16'h1;
        end else if (system_clock_control[7:CKSEL_LSB] == CKSEL_SUB ? low_stable
                                                                      : HIGH_STABLE) begin
          next_settle = 16'h0;
          // A watchdog wake restarts the program, so it never resumes after the stop.
          next_events.wake_resume = !watchdog_expired_flag &&
                                    (!IRQ_SERVICEABLE || !irq_wake);
          next_mode = (system_clock_control[7:CKSEL_LSB] == CKSEL_SUB) ? OMPC_SLOW
                                                                       : OMPC_FAST;
        end
      end
      default: next_mode = OMPC_FAST;
    endcase
    if (CPU_CLEAR_WATCHDOG && !CPU_STOP) next_power_down_flag = 1'b0;
  end

  always_comb begin
    // Taken from the next mode so the clock controls and MODE change on one edge.
    next_clock_ctl.halt_cpu = !(next_mode == OMPC_FAST || next_mode == OMPC_SLOW);
    next_clock_ctl.high_clock_on = !(next_mode == OMPC_SLEEP || next_mode == OMPC_IDLE_SLOW);
    next_clock_ctl.sub_clock_on = !(next_mode == OMPC_SLEEP || next_mode == OMPC_IDLE_FAST);
    next_clock_ctl.sub_from_crystal = system_clock_control[LOW_SRC_BIT];
    next_clock_ctl.divide_sel = system_clock_control[7:CKSEL_LSB];
    next_clock_ctl.use_sub_clock = (next_mode == OMPC_SLOW);
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      mode <= OMPC_FAST;
      settle <= 16'h0;
      irq_mask <= '0;
      power_down_flag <= 1'b0;
      watchdog_expired_flag <= 1'b0;
      EVENTS <= '0;
      CLOCK_CTL <= '{1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 1'b0};
    end else begin
      mode <= next_mode;
      settle <= next_settle;
      irq_mask <= next_irq_mask;
      power_down_flag <= next_power_down_flag;
      watchdog_expired_flag <= next_watchdog_expired_flag;
      EVENTS <= next_events;
      CLOCK_CTL <= next_clock_ctl;
    end
  end

  assign MODE = mode;
endmodule : ompc_controller
`default_nettype wire

/* testbench/ompc_controller_properties.sv */
// Port-level checks of the operating mode controller, bound into it.
`default_nettype none
module ompc_controller_properties
  import ompc_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Watched inputs
  input wire logic CPU_STOP,
  input wire logic WATCHDOG_OVERFLOW,
  input wire logic WATCHDOG_ENABLED,
  input wire logic LOW_CRYSTAL_STABLE,
  input wire logic LOW_RC_STABLE,
  // Watched outputs
  input wire ompc_pkg::ompc_clock_ctl_t CLOCK_CTL,
  input wire ompc_pkg::ompc_events_t EVENTS,
  input wire ompc_pkg::ompc_mode_t MODE
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  logic [7:0] rst_cnt;
  logic [7:0] next_rst_cnt;
  logic stopped;
  logic running;
  // The settle counter saturates so a long oscillator wait never wraps it.
  always_comb begin
    next_rst_cnt = 8'h00;
    if (MODE == OMPC_RESTART) begin
      next_rst_cnt = (rst_cnt == 8'hff) ? rst_cnt : rst_cnt + 8'h01;
    end
  end
  always_ff @(posedge CLOCK) begin
    rst_cnt <= RESET ? 8'h00 : next_rst_cnt;
  end
  assign stopped = MODE inside {OMPC_SLEEP, OMPC_IDLE_SLOW, OMPC_IDLE_BOTH, OMPC_IDLE_FAST};
  assign running = MODE inside {OMPC_FAST, OMPC_SLOW};
  ////////////////////////////////////////////////////////////////////////////////
  property p_stop_enter;
    CPU_STOP && running |=> stopped;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop not entered");
  property p_stop_wdclr;
    CPU_STOP && running |=> EVENTS.watchdog_clear;
  endproperty
  a_stop_wdclr: assert property (p_stop_wdclr) else $error("no watchdog clear");
  property p_sleep;
    MODE == OMPC_SLEEP |->
      !CLOCK_CTL.high_clock_on && !CLOCK_CTL.sub_clock_on && CLOCK_CTL.halt_cpu;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");
  property p_idle_slow;
    MODE == OMPC_IDLE_SLOW |->
      !CLOCK_CTL.high_clock_on && CLOCK_CTL.sub_clock_on && CLOCK_CTL.halt_cpu;
  endproperty
  a_idle_slow: assert property (p_idle_slow) else $error("idle slow clocks wrong");
  property p_idle_both;
    MODE == OMPC_IDLE_BOTH |->
      CLOCK_CTL.high_clock_on && CLOCK_CTL.sub_clock_on && CLOCK_CTL.halt_cpu;
  endproperty
  a_idle_both: assert property (p_idle_both) else $error("idle both clocks wrong");
  property p_idle_fast;
    MODE == OMPC_IDLE_FAST |->
      CLOCK_CTL.high_clock_on && !CLOCK_CTL.sub_clock_on && CLOCK_CTL.halt_cpu;
  endproperty
  a_idle_fast: assert property (p_idle_fast) else $error("idle fast clocks wrong");
  property p_slow_clk;
    MODE == OMPC_SLOW |-> CLOCK_CTL.use_sub_clock;
  endproperty
  a_slow_clk: assert property (p_slow_clk) else $error("slow mode not on sub");
  property p_fast_clk;
    MODE == OMPC_FAST |-> !CLOCK_CTL.use_sub_clock;
  endproperty
  a_fast_clk: assert property (p_fast_clk) else $error("fast mode on sub");
  property p_slow_src;
    $rose(MODE == OMPC_SLOW) |->
      (CLOCK_CTL.sub_from_crystal ? $past(LOW_CRYSTAL_STABLE) : $past(LOW_RC_STABLE));
  endproperty
  a_slow_src: assert property (p_slow_src) else $error("slow before stable");
  property p_wd_wake;
    WATCHDOG_OVERFLOW && WATCHDOG_ENABLED && stopped |-> ##[1:4] EVENTS.wake_watchdog_reset;
  endproperty
  a_wd_wake: assert property (p_wd_wake) else $error("no watchdog reset");
  property p_restart;
    MODE == OMPC_RESTART && rst_cnt < RESTART_CYCLES - 1 |=> MODE == OMPC_RESTART;
  endproperty
  a_restart: assert property (p_restart) else $error("settle cut short");
  property p_full_reset;
    EVENTS.wake_full_reset |-> ##[0:1] MODE == OMPC_FAST;
  endproperty
  a_full_reset: assert property (p_full_reset) else $error("reset wake not fast");
endmodule : ompc_controller_properties

bind ompc_controller ompc_controller_properties u_props (.CLOCK(CLOCK), .RESET(RESET),
  .CPU_STOP(CPU_STOP), .WATCHDOG_OVERFLOW(WATCHDOG_OVERFLOW),
  .WATCHDOG_ENABLED(WATCHDOG_ENABLED),
  .LOW_CRYSTAL_STABLE(LOW_CRYSTAL_STABLE), .LOW_RC_STABLE(LOW_RC_STABLE),
  .CLOCK_CTL(CLOCK_CTL), .EVENTS(EVENTS), .MODE(MODE));
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the operating mode controller.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ompc_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic stop = 1'h0, clrwd = 1'h0, hi_ok = 1'h1, xt_ok = 1'h0, rc_ok = 1'h0;
  logic wd_ovf = 1'h0, ext_n = 1'h1, wd_en = 1'h1, irq_ok = 1'h0;
  logic [7:0] irq = 8'h00;
  logic [7:0] pa = 8'hff;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  ompc_clock_ctl_t cctl;
  ompc_events_t ev;
  ompc_mode_t mode;
  ompc_mode_t modes [4] = '{OMPC_SLEEP, OMPC_IDLE_SLOW, OMPC_IDLE_FAST, OMPC_IDLE_BOTH};
  logic [65:0] expq [$];
  int failures = 0, num_checks = 0, cycles = 0, seed = 65178;

  ompc_controller u_dut (.CLOCK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CPU_STOP(stop),
    .CPU_CLEAR_WATCHDOG(clrwd), .IRQ_PENDING(irq), .IRQ_SERVICEABLE(irq_ok),
    .HIGH_STABLE(hi_ok), .LOW_CRYSTAL_STABLE(xt_ok), .LOW_RC_STABLE(rc_ok),
    .WATCHDOG_ENABLED(wd_en), .WATCHDOG_OVERFLOW(wd_ovf), .PORT_A(pa), .EXT_RESET_N(ext_n),
    .CLOCK_CTL(cctl), .EVENTS(ev), .MODE(mode));

  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Readies are sampled mid-cycle, so a request is released only after the edge taking it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ka, kw, ok;
    expq.push_back({32'h0, RESP_OKAY, 32'h0});
    ka = 1'h1;
    kw = 1'h1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk);
      ka = ka && !awready;
      kw = kw && !wready;
      @(posedge clk);
      awvalid <= ka;
      wvalid <= kw;
    end while (ka || kw);
    do begin @(negedge clk); ok = bvalid; @(posedge clk); end while (!ok);
    bready <= 1'h0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [1:0] r,
                    input logic [31:0] d);
    logic ok;
    expq.push_back({m, r, d});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin @(negedge clk); ok = arready; @(posedge clk); end while (!ok);
    arvalid <= 1'h0;
    do begin @(negedge clk); ok = rvalid; @(posedge clk); end while (!ok);
    rready <= 1'h0;
    @(posedge clk);
  endtask : rd

  // With want low the full window is watched and any pulse of the event counts as a mismatch.
  task automatic wait_ev(input int b, input logic want);
    logic ok;
    int n;
    n = 0;
    do begin @(negedge clk); ok = ev[b]; n++; @(posedge clk); end while (!ok && n < 300);
    check(ok, want);
  endtask : wait_ev

  task automatic halt_now;
    stop <= 1'h1;
    @(posedge clk);
    stop <= 1'h0;
    tick(3);
  endtask : halt_now
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    logic [65:0] e;
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = expq.pop_front();
      check(bvalid ? bresp : rresp, e[33:32]);
      check(rdata & e[65:34] & {32{!bvalid}}, e[31:0] & e[65:34]);
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    logic [31:0] d;
    tick(6);
    rst <= 1'h0;
    @(posedge clk);
    check(cctl, 32'h60);
    rd(SYS_CLOCK_CONTROL_OFS, 32'hffffffff, RESP_OKAY, 32'h0);
    rd(POWER_STATUS_OFS, 32'hffffffff, RESP_OKAY, 32'h0);
    rd(8'h10, 32'h0, RESP_SLVERR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(PORT_A_WAKE_ENABLE_OFS, d);
      rd(PORT_A_WAKE_ENABLE_OFS, 32'hffffffff, RESP_OKAY, d & 32'hff);
    end
    for (int s = 0; s < 7; s++) begin
      wr(SYS_CLOCK_CONTROL_OFS, s << CKSEL_LSB);
      tick(2);
      check(cctl.divide_sel, s[2:0]);
    end
    wr(SYS_CLOCK_CONTROL_OFS, 32'he0);
    tick(10);
    rd(POWER_STATUS_OFS, 32'h70, RESP_OKAY, 32'h00);
    rc_ok <= 1'h1;
    tick(10);
    rd(POWER_STATUS_OFS, 32'h70, RESP_OKAY, 32'h10);
    check(cctl.sub_from_crystal, 32'h0);
    wr(SYS_CLOCK_CONTROL_OFS, 32'h0);
    xt_ok <= 1'h1;
    wr(SYS_CLOCK_CONTROL_OFS, 32'he4);
    tick(10);
    check(cctl.sub_from_crystal, 32'h1);
    rd(OSC_STATUS_OFS, 32'hffffffff, RESP_OKAY, 32'h7);
    wr(PORT_A_WAKE_ENABLE_OFS, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(SYS_CLOCK_CONTROL_OFS, k);
      halt_now();
      rd(POWER_STATUS_OFS, 32'hffffffff, RESP_OKAY, {25'h0, modes[k], 4'h1});
      check(cctl.high_clock_on, k[1]);
      check(cctl.sub_clock_on, k[0]);
      pa <= 8'hfd;
      tick(12);
      rd(POWER_STATUS_OFS, 32'h70, RESP_OKAY, {25'h0, modes[k], 4'h0});
      rd(PORT_A_WAKE_ENABLE_OFS, 32'hff, RESP_OKAY, 32'h1);
      pa <= 8'hfc;
      wait_ev(1, 1'h1);
      rd(POWER_STATUS_OFS, 32'hffffffff, RESP_OKAY, 32'h1);
      pa <= 8'hff;
    end
    clrwd <= 1'h1;
    @(posedge clk);
    clrwd <= 1'h0;
    tick(2);
    rd(POWER_STATUS_OFS, 32'h1, RESP_OKAY, 32'h0);
    halt_now();
    wd_ovf <= 1'h1;
    @(posedge clk);
    wd_ovf <= 1'h0;
    wait_ev(2, 1'h1);
    rd(POWER_STATUS_OFS, 32'h3, RESP_OKAY, 32'h3);
    wait_ev(1, 1'h0);
    irq <= 8'h01;
    halt_now();
    tick(10);
    rd(POWER_STATUS_OFS, 32'h70, RESP_OKAY, 32'h40);
    irq <= 8'h03;
    wait_ev(1, 1'h1);
    irq <= 8'h00;
    irq_ok <= 1'h1;
    tick(5);
    halt_now();
    irq <= 8'h04;
    wait_ev(1, 1'h0);
    rd(POWER_STATUS_OFS, 32'h70, RESP_OKAY, 32'h0);
    irq <= 8'h00;
    wd_en <= 1'h0;
    tick(5);
    halt_now();
    wd_ovf <= 1'h1;
    @(posedge clk);
    wd_ovf <= 1'h0;
    tick(3);
    rd(POWER_STATUS_OFS, 32'h72, RESP_OKAY, 32'h40);
    wd_en <= 1'h1;
    ext_n <= 1'h0;
    wait_ev(3, 1'h1);
    ext_n <= 1'h1;
    tick(5);
    rd(POWER_STATUS_OFS, 32'h70, RESP_OKAY, 32'h0);
    summarize();
  end
endmodule : tb
`default_nettype wire
